//--- rtl/xcs_map.vh
`ifndef XCS_MAP_VH
`define XCS_MAP_VH
// ----------------------------------------
// opcode patterns
// ----------------------------------------
`define XCS_OP_XORL      6'h3A
`define XCS_OP_XORF      6'h06
`define XCS_OP_CALL      3'h4
`define XCS_OP_BTSC      4'h6
// ----------------------------------------
// field positions
// ----------------------------------------
`define XCS_TOP6_HI      13
`define XCS_TOP6_LO      8
`define XCS_TOP3_LO      11
`define XCS_TOP4_LO      10
`define XCS_DEST_BIT     7
`define XCS_BIT_HI       9
`define XCS_BIT_LO       7
`define XCS_DEST_ACC     1'h0
`define XCS_DEST_FILE    1'h1
// ----------------------------------------
// phases and cycle counts
// ----------------------------------------
`define XCS_PH_DECODE    2'h0
`define XCS_PH_READ      2'h1
`define XCS_PH_PROC      2'h2
`define XCS_PH_WRITE     2'h3
`define XCS_CALL_CYCLES  2
// ----------------------------------------
// reset values
// ----------------------------------------
`define XCS_ACC_RST      8'h00
`define XCS_PC_RST       13'h0000
`endif

//--- rtl/xcs_phase_seq.v
`timescale 1ns/1ps
`include "xcs_map.vh"
module xcs_phase_seq (
	// clock and reset
	input  wire       clk_sys,
	input  wire       sys_rst,
	// phase outputs
	output reg  [1:0] phase_reg,
	output reg        cycle_end_reg
);
	// ----------------------------------------
	// four-phase counter
	// ----------------------------------------
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			phase_reg     <= `XCS_PH_DECODE;
			cycle_end_reg <= 1'b0;
		end else begin
			phase_reg     <= phase_reg + 2'h1;
			cycle_end_reg <= (phase_reg == `XCS_PH_PROC);
		end
	end
endmodule // xcs_phase_seq

//--- rtl/xcs_exec.v
// Summary of operation
// - A call takes two instruction cycles of four phases each.
// - Call cycle one decodes, reads the target and pushes pc plus one, processes, writes the pc.
// - Call cycle two is four no-operation phases while the pipeline refills.
// - A taken skip adds one all-no-operation cycle that discards the next instruction.
// - Bit-test-skip-if-clear decodes, reads the file, tests the bit, and writes nothing.
// - Literal xor is decoded from top six bits 111010 with an eight-bit literal below.
// - Literal xor puts accumulator xor literal into the accumulator in one cycle.
// - File xor is decoded from top six bits 000110, a destination bit, a seven-bit address.
// - File xor destination 0 writes the accumulator, 1 writes the file register.
// - Call is decoded from top three bits 100 with an eleven-bit target below.
`timescale 1ns/1ps
`include "xcs_map.vh"
module xcs_exec (
	// clock and reset
	input  wire        clk_sys,
	input  wire        sys_rst,
	// instruction fetch
	input  wire [13:0] instr_word,
	output reg         fetch_strobe_reg,
	// register file
	input  wire [7:0]  file_rd_data,
	output reg  [6:0]  file_addr_reg,
	output reg  [7:0]  file_wr_data_reg,
	output reg         file_wr_en_reg,
	// stack and program counter
	input  wire [1:0]  pc_high_latch,
	output reg  [12:0] pc_reg,
	output reg  [12:0] stack_push_data_reg,
	output reg         stack_push_reg,
	// status
	output reg  [7:0]  acc_reg,
	output reg         zero_flag_reg,
	output reg         zero_wr_reg,
	output reg  [1:0]  phase_out_reg,
	output reg         nop_cycle_reg
);
	// ----------------------------------------
	// decode classes
	// ----------------------------------------
	localparam CLS_NONE = 3'h0;
	localparam CLS_XORL = 3'h1;
	localparam CLS_XORF = 3'h2;
	localparam CLS_CALL = 3'h3;
	localparam CLS_BTSC = 3'h4;

	wire [1:0] phase;
	wire       cycle_end;
	reg  [2:0] cls_reg;
	reg  [2:0] cls_next;
	reg [13:0] ir_reg;
	reg  [7:0] operand_reg;
	reg  [7:0] result_reg;
	reg        skip_reg;
	reg        flush_reg;
	wire [7:0] xor_res;
	wire [2:0] bit_sel;

	xcs_phase_seq u_seq (
		.clk_sys       (clk_sys),
		.sys_rst       (sys_rst),
		.phase_reg     (phase),
		.cycle_end_reg (cycle_end)
	);

	assign xor_res = acc_reg ^ operand_reg;
	assign bit_sel = ir_reg[`XCS_BIT_HI:`XCS_BIT_LO];

	// ----------------------------------------
	// instruction decode
	// ----------------------------------------
	always @* begin
		cls_next = CLS_NONE;
		if (instr_word[`XCS_TOP6_HI:`XCS_TOP6_LO] == `XCS_OP_XORL) begin
			cls_next = CLS_XORL;
		end else if (instr_word[`XCS_TOP6_HI:`XCS_TOP6_LO] == `XCS_OP_XORF) begin
			cls_next = CLS_XORF;
		end else if (instr_word[`XCS_TOP6_HI:`XCS_TOP3_LO] == `XCS_OP_CALL) begin
			cls_next = CLS_CALL;
		end else if (instr_word[`XCS_TOP6_HI:`XCS_TOP4_LO] == `XCS_OP_BTSC) begin
			cls_next = CLS_BTSC;
		end
	end

	// ----------------------------------------
	// phase execution
	// ----------------------------------------
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cls_reg             <= CLS_NONE;
			ir_reg              <= 14'h0000;
			operand_reg         <= 8'h00;
			result_reg          <= 8'h00;
			skip_reg            <= 1'b0;
			flush_reg           <= 1'b0;
			fetch_strobe_reg    <= 1'b0;
			file_addr_reg       <= 7'h00;
			file_wr_data_reg    <= 8'h00;
			file_wr_en_reg      <= 1'b0;
			pc_reg              <= `XCS_PC_RST;
			stack_push_data_reg <= `XCS_PC_RST;
			stack_push_reg      <= 1'b0;
			acc_reg             <= `XCS_ACC_RST;
			zero_flag_reg       <= 1'b0;
			zero_wr_reg         <= 1'b0;
			phase_out_reg       <= `XCS_PH_DECODE;
			nop_cycle_reg       <= 1'b0;
		end else begin
			phase_out_reg    <= phase;
			fetch_strobe_reg <= 1'b0;
			file_wr_en_reg   <= 1'b0;
			stack_push_reg   <= 1'b0;
			zero_wr_reg      <= 1'b0;
			case (phase)
			`XCS_PH_DECODE: begin
				if (flush_reg) begin
					cls_reg       <= CLS_NONE;
					nop_cycle_reg <= 1'b1;
				end else begin
					cls_reg       <= cls_next;
					ir_reg        <= instr_word;
					file_addr_reg <= instr_word[6:0];
					nop_cycle_reg <= 1'b0;
				end
			end
			`XCS_PH_READ: begin
				case (cls_reg)
				CLS_XORL: operand_reg <= ir_reg[7:0];
				CLS_XORF: operand_reg <= file_rd_data;
				CLS_BTSC: operand_reg <= file_rd_data;
				CLS_CALL: begin
					stack_push_data_reg <= pc_reg + 13'h0001;
					stack_push_reg      <= 1'b1;
				end
				default: operand_reg <= operand_reg;
				endcase
			end
			`XCS_PH_PROC: begin
				result_reg <= xor_res;
				skip_reg   <= (cls_reg == CLS_BTSC) && !operand_reg[bit_sel];
			end
			`XCS_PH_WRITE: begin
				flush_reg        <= 1'b0;
				fetch_strobe_reg <= cycle_end;
				pc_reg           <= pc_reg + 13'h0001;
				case (cls_reg)
				CLS_XORL: begin
					acc_reg       <= result_reg;
					zero_flag_reg <= (result_reg == 8'h00);
					zero_wr_reg   <= 1'b1;
				end
				CLS_XORF: begin
					if (ir_reg[`XCS_DEST_BIT] == `XCS_DEST_ACC) begin
						acc_reg <= result_reg;
					end else begin
						file_wr_data_reg <= result_reg;
						file_wr_en_reg   <= 1'b1;
					end
					zero_flag_reg <= (result_reg == 8'h00);
					zero_wr_reg   <= 1'b1;
				end
				CLS_CALL: begin
					pc_reg    <= {pc_high_latch, ir_reg[10:0]};
					flush_reg <= 1'b1;
				end
				CLS_BTSC: begin
					flush_reg <= skip_reg;
				end
				default: flush_reg <= 1'b0;
				endcase
			end
			default: cls_reg <= CLS_NONE;
			endcase
		end
	end
endmodule // xcs_exec

//--- test/xcs_exec_props.sv
`timescale 1ns/1ps
module xcs_exec_props (
	// watched ports
	input wire       clk_sys,
	input wire       sys_rst,
	input wire       fetch_strobe_reg,
	input wire [7:0] file_wr_data_reg,
	input wire       file_wr_en_reg,
	input wire       stack_push_reg,
	input wire [7:0] acc_reg,
	input wire       zero_flag_reg,
	input wire       zero_wr_reg,
	input wire       nop_cycle_reg
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	chk_call_two_cycles: assert property (stack_push_reg |-> ##2 fetch_strobe_reg ##4 fetch_strobe_reg)
		else $error("call length wrong");
	chk_push_single: assert property (stack_push_reg |=> !stack_push_reg)
		else $error("push not a pulse");
	chk_call_nop: assert property (stack_push_reg |-> ##[1:4] nop_cycle_reg)
		else $error("no flush after call");
	chk_nop_no_write: assert property (nop_cycle_reg |-> !file_wr_en_reg && !zero_wr_reg)
		else $error("write in flush cycle");
	chk_strobe_gap: assert property (fetch_strobe_reg |=> !fetch_strobe_reg [*3])
		else $error("cycle shorter than four");
	chk_zero_value: assert property (zero_wr_reg |->
		zero_flag_reg == (file_wr_en_reg ? file_wr_data_reg == 8'h00 : acc_reg == 8'h00))
		else $error("zero flag wrong");
	chk_write_phase: assert property (zero_wr_reg |-> fetch_strobe_reg)
		else $error("write outside last phase");
	chk_acc_cause: assert property ($changed(acc_reg) |-> zero_wr_reg && !file_wr_en_reg)
		else $error("acc changed without cause");
endmodule // xcs_exec_props
bind xcs_exec xcs_exec_props u_props (.clk_sys, .sys_rst, .fetch_strobe_reg, .file_wr_data_reg,
	.file_wr_en_reg, .stack_push_reg, .acc_reg, .zero_flag_reg, .zero_wr_reg, .nop_cycle_reg);

//--- test/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic        clk_sys = 0, sys_rst = 1, fetch_strobe_reg, file_wr_en_reg;
	logic        stack_push_reg, zero_flag_reg, zero_wr_reg, nop_cycle_reg;
	logic [13:0] instr_word = 14'h0000;
	logic [7:0]  file_rd_data = 8'h00, file_wr_data_reg, acc_reg;
	logic [1:0]  pc_high_latch = 2'h0, phase_out_reg;
	logic [6:0]  file_addr_reg;
	logic [12:0] pc_reg, stack_push_data_reg;
	integer      err_count = 0, checks_done = 0;
	xcs_exec DUT (.clk_sys, .sys_rst, .instr_word, .fetch_strobe_reg, .file_rd_data,
		.file_addr_reg, .file_wr_data_reg, .file_wr_en_reg, .pc_high_latch, .pc_reg,
		.stack_push_data_reg, .stack_push_reg, .acc_reg, .zero_flag_reg, .zero_wr_reg,
		.phase_out_reg, .nop_cycle_reg);
	initial forever #10 clk_sys = ~clk_sys;
	task chk(input string n, input logic [12:0] e, input logic [12:0] g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task run(input logic [13:0] w, input logic [7:0] d);
		instr_word = w;
		file_rd_data = d;
		do begin @(posedge clk_sys); #1; end while (fetch_strobe_reg !== 1'b1);
	endtask
	task end_sim;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task t_xorl;
		run(14'h3AB5, 8'h00);
		run(14'h3AAF, 8'h00);
		chk("acc", 13'h1A, 13'(acc_reg));
		chk("zero", 13'h0, 13'(zero_flag_reg));
		chk("zwr", 13'h1, 13'(zero_wr_reg));
		chk("phase", 13'h3, 13'(phase_out_reg));
		run(14'h3A1A, 8'h00);
		chk("zero", 13'h1, 13'(zero_flag_reg));
		$display("test xorl done");
	endtask
	task t_xorf;
		run(14'h3AB5, 8'h00);
		run(14'h0625, 8'hAF);
		chk("acc", 13'h1A, 13'(acc_reg));
		chk("addr", 13'h25, 13'(file_addr_reg));
		run(14'h06A5, 8'hAF);
		chk("wdata", 13'hB5, 13'(file_wr_data_reg));
		chk("wen", 13'h1, 13'(file_wr_en_reg));
		chk("acc", 13'h1A, 13'(acc_reg));
		$display("test xorf done");
	endtask
	task t_call;
		pc_high_latch = 2'h2;
		chk("pc", 13'h0006, pc_reg);
		run(14'h2123, 8'h00);
		chk("pc", 13'h1123, pc_reg);
		chk("stack", 13'h0007, stack_push_data_reg);
		run(14'h3AFF, 8'h00);
		chk("acc", 13'h1A, 13'(acc_reg));
		chk("nop", 13'h1, 13'(nop_cycle_reg));
		chk("pc", 13'h1124, pc_reg);
		$display("test call done");
	endtask
	task t_skip;
		run(14'h1990, 8'hF7);
		chk("wen", 13'h0, 13'(file_wr_en_reg));
		chk("zwr", 13'h0, 13'(zero_wr_reg));
		run(14'h3AFF, 8'h00);
		chk("acc", 13'h1A, 13'(acc_reg));
		chk("nop", 13'h1, 13'(nop_cycle_reg));
		run(14'h1990, 8'h08);
		chk("nop", 13'h0, 13'(nop_cycle_reg));
		run(14'h3AFF, 8'h00);
		chk("acc", 13'hE5, 13'(acc_reg));
		$display("test skip done");
	endtask
	initial begin
		repeat (2) @(posedge clk_sys);
		#1 sys_rst = 0;
		t_xorl;
		t_xorf;
		t_call;
		t_skip;
		end_sim;
	end
	initial begin
		repeat (400) @(posedge clk_sys);
		err_count++;
		end_sim;
	end
endmodule // testbench
